/* File: dv/ssme_host.sv */
module ssme_host (
   input wire clk,
   input wire sda,
   output logic scl,
   output logic sda_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   // ***************************************************
   // Serial controller, 48 ns bit clock, idle high
   // ***************************************************
   initial
   begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end
   // Data moves mid low phase so it is stable while the clock is high
   task put(input logic b);
      sda_oe = ~b; #12; scl = 1'b1; #24; scl = 1'b0; #12;
   endtask
   task get(output logic b);
      sda_oe = 1'b0; #12; scl = 1'b1; #12; b = sda; #12; scl = 1'b0; #12;
   endtask
   task go;
      sda_oe = 1'b0; #12; scl = 1'b1; #24; sda_oe = 1'b1; #24; scl = 1'b0; #12;
   endtask
   task halt;
      sda_oe = 1'b1; #12; scl = 1'b1; #24; sda_oe = 1'b0; #24;
   endtask
   task tx(input logic [7:0] d, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) put(d[i]);
      get(a);
      ack = ~a;
   endtask
   task wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d, output logic ok);
      logic k1, k2, k3;
      @(posedge clk); #1;
      go;
      tx({a, 1'b0}, k1);
      tx(p, k2);
      tx(d, k3);
      halt;
      ok = k1 & k2 & k3;
   endtask
   task rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d);
      logic k;
      @(posedge clk); #1;
      go;
      tx({a, 1'b0}, k);
      tx(p, k);
      go;
      tx({a, 1'b1}, k);
      for (int i = 7; i >= 0; i--) get(d[i]);
      put(1'b1);
      halt;
   endtask
endmodule

/* File: dv/ssme_regbank_sva.sv */
module ssme_regbank_sva (
   input wire REF_CLK,
   input wire RST,
   input wire CE,
   input wire SCL_IN,
   input wire SDA_IN,
   input wire SDA_OUT,
   input wire SDA_OE,
   input wire POWER_FAIL_BELOW,
   input wire LOW_BATTERY_BELOW,
   input wire [4:0] SUPPLY_BELOW_TARGET,
   input wire CORE_VOLTAGE_TRANSITION,
   input wire CONV1_ENABLE_PIN,
   input wire CONV2_ENABLE_PIN,
   input wire CONV3_ENABLE_PIN,
   input wire LINREG_ENABLE_PIN,
   input wire [4:0] SUPPLY_ON,
   input wire INT_N
);
   timeunit 1ns;
   timeprecision 1ps;
   // ***************************************************
   // Checks
   // ***************************************************
   // ***************************************************
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (RST);
   // Open drain: the data value is only ever low
   sda_value_low_a: assert property (SDA_OUT == 1'b0)
      else $error("data pin value not low");
   conv1_off_a: assert property (!CONV1_ENABLE_PIN [*5] |-> !SUPPLY_ON[4])
      else $error("conv1 on with pin low");
   conv2_off_a: assert property (!CONV2_ENABLE_PIN [*5] |-> !SUPPLY_ON[3])
      else $error("conv2 on with pin low");
   conv3_off_a: assert property (!CONV3_ENABLE_PIN [*5] |-> !SUPPLY_ON[2])
      else $error("conv3 on with pin low");
   linreg_off_a: assert property (!LINREG_ENABLE_PIN [*5] |-> SUPPLY_ON[1:0] == 2'b00)
      else $error("linreg on with pin low");
   conv3_rise_a: assert property ($rose(SUPPLY_ON[2]) |-> $past(CONV3_ENABLE_PIN, 2))
      else $error("conv3 on without pin");
   linreg_return_a: assert property (!LINREG_ENABLE_PIN [*4] ##1 LINREG_ENABLE_PIN [*5]
      |-> SUPPLY_ON[1:0] == 2'b11)
      else $error("linreg not back on");
   int_quiet_a: assert property ((SUPPLY_BELOW_TARGET == 5'h00 && !POWER_FAIL_BELOW
      && !LOW_BATTERY_BELOW) [*5] |-> INT_N)
      else $error("interrupt without fault");
   sda_low_phase_a: assert property ($changed(SDA_OE) |-> !SCL_IN && !$past(SCL_IN, 2))
      else $error("data changed with clock high");
   cover property ($fell(INT_N));
   cover property ($rose(SDA_OE));
   cover property ($rose(SUPPLY_ON[1]));
endmodule

bind ssme_regbank ssme_regbank_sva u_sva (.REF_CLK(REF_CLK), .RST(RST), .CE(CE),
   .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
   .POWER_FAIL_BELOW(POWER_FAIL_BELOW), .LOW_BATTERY_BELOW(LOW_BATTERY_BELOW),
   .SUPPLY_BELOW_TARGET(SUPPLY_BELOW_TARGET), .CORE_VOLTAGE_TRANSITION(CORE_VOLTAGE_TRANSITION),
   .CONV1_ENABLE_PIN(CONV1_ENABLE_PIN), .CONV2_ENABLE_PIN(CONV2_ENABLE_PIN),
   .CONV3_ENABLE_PIN(CONV3_ENABLE_PIN), .LINREG_ENABLE_PIN(LINREG_ENABLE_PIN),
   .SUPPLY_ON(SUPPLY_ON), .INT_N(INT_N));

/* File: dv/testbench.sv */
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   // ***************************************************
   // Bench
   // ***************************************************
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic pf = 1'b0;
   logic lb = 1'b0;
   logic cvt = 1'b0;
   logic [4:0] below = 5'h00;
   logic [3:0] en = 4'hF;
   logic [7:0] rv;
   logic ok;
   int bad_count = 0;
   int cmp_count = 0;
   wire scl, host_oe, sda_out, dut_oe, int_n;
   wire [4:0] supply_on;
   // Pulled-up wire: low while either side drives
   wire sda = ~(host_oe | dut_oe);
   always #2 ref_clk = ~ref_clk;
   // Revision value is arbitrary
   ssme_regbank #(.REVISION_CODE(8'h3C)) dut (.REF_CLK(ref_clk), .RST(rst), .CE(1'b1),
      .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(dut_oe),
      .POWER_FAIL_BELOW(pf), .LOW_BATTERY_BELOW(lb), .SUPPLY_BELOW_TARGET(below),
      .CORE_VOLTAGE_TRANSITION(cvt), .CONV1_ENABLE_PIN(en[3]), .CONV2_ENABLE_PIN(en[2]),
      .CONV3_ENABLE_PIN(en[1]), .LINREG_ENABLE_PIN(en[0]), .SUPPLY_ON(supply_on),
      .INT_N(int_n));
   ssme_host host (.clk(ref_clk), .sda(sda), .scl(scl), .sda_oe(host_oe));
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task close_out;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task wait_n(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task rdc(input logic [7:0] p, input logic [7:0] e);
      host.rd(7'h48, p, rv);
      chk(rv, e);
   endtask
   task wr(input logic [7:0] p, input logic [7:0] d);
      host.wr(7'h48, p, d, ok);
      chk({7'h00, ok}, 8'h01);
      wait_n(8);
   endtask
   // Hang guard
   initial
   begin
      #300us;
      bad_count++;
      close_out;
   end
   initial
   begin
      wait_n(12);
      rst = 1'b0;
      wait_n(6);
      rdc(8'h00, 8'h3C);
      rdc(8'h02, 8'hC0);
      rdc(8'h03, 8'hFF);
      rdc(8'h04, 8'hFF);
      rdc(8'hA7, 8'hFF);
      pf = 1'b1;
      below = 5'b10101;
      wait_n(8);
      chk({7'h00, int_n}, 8'h00);
      wr(8'h02, 8'hFF);
      chk({7'h00, int_n}, 8'h01);
      rdc(8'h02, 8'hFE);
      wr(8'h02, 8'h00);
      chk({7'h00, int_n}, 8'h00);
      rdc(8'h01, 8'hAA);
      wait_n(8);
      chk({7'h00, int_n}, 8'h01);
      wr(8'h01, 8'h00);
      rdc(8'h01, 8'hAA);
      cvt = 1'b1;
      wait_n(8);
      rdc(8'h01, 8'hA2);
      cvt = 1'b0;
      wr(8'h03, 8'h00);
      chk({3'h0, supply_on}, 8'h00);
      rdc(8'h03, 8'hC1);
      rdc(8'h01, 8'h80);
      wr(8'h03, 8'h10);
      chk({3'h0, supply_on}, 8'h08);
      en = 4'h0;
      wait_n(10);
      en = 4'hF;
      wait_n(8);
      rdc(8'h03, 8'hFF);
      chk({3'h0, supply_on}, 8'h1F);
      host.wr(7'h49, 8'h02, 8'h3E, ok);
      chk({7'h00, ok}, 8'h00);
      rdc(8'h02, 8'h00);
      rst = 1'b1;
      wait_n(2);
      rst = 1'b0;
      wait_n(6);
      rdc(8'h02, 8'hC0);
      rdc(8'h03, 8'hFF);
      close_out;
   end
endmodule

/* File: include/ssme_regs.vh */
`ifndef SSME_REGS_VH
`define SSME_REGS_VH

// ******************************************************************
// Register offsets
// ******************************************************************
`define SSME_OFS_REVISION 8'h00
`define SSME_OFS_STATUS 8'h01
`define SSME_OFS_MASK 8'h02
`define SSME_OFS_SUPPLY_ON 8'h03

// ******************************************************************
// Field positions
// ******************************************************************
`define SSME_BIT_POWER_FAIL 7
`define SSME_BIT_LOW_BATTERY 6
`define SSME_BIT_CONV1 5
`define SSME_BIT_CONV2 4
`define SSME_BIT_CONV3 3
`define SSME_BIT_LINREG2 2
`define SSME_BIT_LINREG1 1

// ******************************************************************
// Reset and fixed values
// ******************************************************************
`define SSME_MASK_RESET 8'hC0
`define SSME_SUPPLY_ON_RESET 8'hFF
`define SSME_UNMAPPED_READ 8'hFF

// ******************************************************************
// Serial target
// ******************************************************************
`define SSME_TARGET_ADDR 7'h48
`define SSME_BYTE_BITS 4'h8

`endif

/* File: rtl/ssme_regbank.v */
`include "ssme_regs.vh"

module ssme_regbank #(
   parameter [7:0] REVISION_CODE = 8'h5A  // Arbitrary value
) (
   input wire REF_CLK,
   input wire RST,
   input wire CE,
   input wire SCL_IN,
   input wire SDA_IN,
   output reg SDA_OUT,
   output reg SDA_OE,
   input wire POWER_FAIL_BELOW,
   input wire LOW_BATTERY_BELOW,
   input wire [4:0] SUPPLY_BELOW_TARGET,
   input wire CORE_VOLTAGE_TRANSITION,
   input wire CONV1_ENABLE_PIN,
   input wire CONV2_ENABLE_PIN,
   input wire CONV3_ENABLE_PIN,
   input wire LINREG_ENABLE_PIN,
   output reg [4:0] SUPPLY_ON,
   output reg INT_N
);

   // ***************************************************************
   // Input synchronisation
   // ***************************************************************
   wire [13:0] pins_s;
   ssme_sync #(.WIDTH(14)) u_sync (
      .clk(REF_CLK),
      .rst(RST),
      .ce(CE),
      .d({SCL_IN, SDA_IN, POWER_FAIL_BELOW, LOW_BATTERY_BELOW, SUPPLY_BELOW_TARGET,
          CORE_VOLTAGE_TRANSITION, CONV1_ENABLE_PIN, CONV2_ENABLE_PIN,
          CONV3_ENABLE_PIN, LINREG_ENABLE_PIN}),
      .q(pins_s)
   );

   wire scl_s = pins_s[13];
   wire sda_s = pins_s[12];
   wire pf_s = pins_s[11];
   wire lb_s = pins_s[10];
   wire [5:1] below_s = pins_s[9:5];
   wire transition_s = pins_s[4];
   // Shared linear regulator pin feeds both regulator bits
   wire [5:1] en_pin_s = {pins_s[3:0], pins_s[0]};

   // ***************************************************************
   // Register state
   // ***************************************************************
   reg [7:1] mask_q;
   reg [5:1] on_ctrl_q;
   reg [7:1] block_q;
   reg wr_stb_q;
   reg [7:0] wr_ptr_q;
   reg [7:0] wr_data_q;
   reg rd_stat_q;

   reg [7:0] status;
   reg [7:0] rd_data;
   reg [7:0] ptr_q;

   always @*
   begin
      status = 8'h00;
      status[`SSME_BIT_POWER_FAIL] = pf_s;
      status[`SSME_BIT_LOW_BATTERY] = lb_s;
      status[5:1] = below_s & SUPPLY_ON;
      if (transition_s)
         status[`SSME_BIT_CONV3] = 1'b0;
   end

   always @*
   begin
      if (ptr_q == `SSME_OFS_REVISION)
         rd_data = REVISION_CODE;
      else if (ptr_q == `SSME_OFS_STATUS)
         rd_data = status;
      else if (ptr_q == `SSME_OFS_MASK)
         rd_data = {mask_q, 1'b0};
      else if (ptr_q == `SSME_OFS_SUPPLY_ON)
         rd_data = {2'b11, on_ctrl_q, 1'b1};
      else
         rd_data = `SSME_UNMAPPED_READ;
   end

   genvar gi;
   generate
      for (gi = 1; gi <= 5; gi = gi + 1)
      begin : g_supply
         always @(posedge REF_CLK or posedge RST)
         begin
            if (RST)
            begin
               on_ctrl_q[gi] <= 1'b1;
               SUPPLY_ON[gi-1] <= 1'b0;
            end
            else if (CE)
            begin
               // A low pin outranks a write in the same cycle
               if (!en_pin_s[gi])
                  on_ctrl_q[gi] <= 1'b1;
               else if (wr_stb_q && wr_ptr_q == `SSME_OFS_SUPPLY_ON)
                  on_ctrl_q[gi] <= wr_data_q[gi];
               SUPPLY_ON[gi-1] <= on_ctrl_q[gi] & en_pin_s[gi];
            end
         end
      end
   endgenerate

   localparam [7:0] MASK_RST = `SSME_MASK_RESET;
   always @(posedge REF_CLK or posedge RST)
   begin
      if (RST)
      begin
         mask_q <= MASK_RST[7:1];
         block_q <= 7'h00;
         INT_N <= 1'b1;
      end
      else if (CE)
      begin
         if (wr_stb_q && wr_ptr_q == `SSME_OFS_MASK)
            mask_q <= wr_data_q[7:1];
         // Block releases once a bit clears, so a later fault fires again
         if (rd_stat_q)
            block_q <= status[7:1];
         else
            block_q <= block_q & status[7:1];
         INT_N <= ~|(status[7:1] & ~mask_q & ~block_q);
      end
   end

   // ***************************************************************
   // Serial target engine
   // ***************************************************************
   localparam [4:0] ST_IDLE = 5'b00001;
   localparam [4:0] ST_RX = 5'b00010;
   localparam [4:0] ST_ACK = 5'b00100;
   localparam [4:0] ST_TX = 5'b01000;
   localparam [4:0] ST_RACK = 5'b10000;

   reg [4:0] state_q;
   reg scl_prev_q;
   reg sda_prev_q;
   reg [7:0] sh_q;
   reg [3:0] cnt_q;
   reg addr_phase_q;
   reg ptr_phase_q;
   reg read_q;

   wire scl_rise = scl_s & ~scl_prev_q;
   wire scl_fall = ~scl_s & scl_prev_q;
   wire start_cond = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
   wire stop_cond = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

   always @(posedge REF_CLK or posedge RST)
   begin
      if (RST)
      begin
         state_q <= ST_IDLE;
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
         sh_q <= 8'h00;
         cnt_q <= 4'h0;
         addr_phase_q <= 1'b0;
         ptr_phase_q <= 1'b0;
         read_q <= 1'b0;
         ptr_q <= 8'h00;
         SDA_OE <= 1'b0;
         SDA_OUT <= 1'b0;
         wr_stb_q <= 1'b0;
         wr_ptr_q <= 8'h00;
         wr_data_q <= 8'h00;
         rd_stat_q <= 1'b0;
      end
      else if (CE)
      begin
         scl_prev_q <= scl_s;
         sda_prev_q <= sda_s;
         wr_stb_q <= 1'b0;
         rd_stat_q <= 1'b0;
         if (start_cond)
         begin
            state_q <= ST_RX;
            cnt_q <= 4'h0;
            addr_phase_q <= 1'b1;
            SDA_OE <= 1'b0;
         end
         else if (stop_cond)
         begin
            state_q <= ST_IDLE;
            SDA_OE <= 1'b0;
         end
         else
         begin
            case (state_q)
               ST_RX:
               begin
                  if (scl_rise && cnt_q != `SSME_BYTE_BITS)
                  begin
                     sh_q <= {sh_q[6:0], sda_s};
                     cnt_q <= cnt_q + 4'h1;
                  end
                  else if (scl_fall && cnt_q == `SSME_BYTE_BITS)
                  begin
                     cnt_q <= 4'h0;
                     if (addr_phase_q)
                     begin
                        addr_phase_q <= 1'b0;
                        if (sh_q[7:1] == `SSME_TARGET_ADDR)
                        begin
                           read_q <= sh_q[0];
                           ptr_phase_q <= ~sh_q[0];
                           SDA_OE <= 1'b1;
                           state_q <= ST_ACK;
                        end
                        else
                           state_q <= ST_IDLE;
                     end
                     else
                     begin
                        if (ptr_phase_q)
                        begin
                           ptr_q <= sh_q;
                           ptr_phase_q <= 1'b0;
                        end
                        else
                        begin
                           wr_stb_q <= 1'b1;
                           wr_ptr_q <= ptr_q;
                           wr_data_q <= sh_q;
                        end
                        SDA_OE <= 1'b1;
                        state_q <= ST_ACK;
                     end
                  end
               end
               ST_ACK:
               begin
                  if (scl_fall)
                     if (read_q)
                     begin
                        sh_q <= {rd_data[6:0], 1'b0};
                        SDA_OE <= ~rd_data[7];
                        cnt_q <= 4'h1;
                        rd_stat_q <= (ptr_q == `SSME_OFS_STATUS);
                        state_q <= ST_TX;
                     end
                     else
                     begin
                        SDA_OE <= 1'b0;
                        state_q <= ST_RX;
                     end
               end
               ST_TX:
               begin
                  if (scl_fall)
                     if (cnt_q == `SSME_BYTE_BITS)
                     begin
                        SDA_OE <= 1'b0;
                        state_q <= ST_RACK;
                     end
                     else
                     begin
                        SDA_OE <= ~sh_q[7];
                        sh_q <= {sh_q[6:0], 1'b0};
                        cnt_q <= cnt_q + 4'h1;
                     end
               end
               ST_RACK:
               begin
                  // No acknowledge ends the read; line stays released for stop
                  if (scl_rise)
                     state_q <= sda_s ? ST_IDLE : ST_ACK;
               end
               default:
                  SDA_OE <= 1'b0;
            endcase
         end
      end
   end

endmodule

/* File: rtl/ssme_sync.v */
// ******************************************************************
// Two-stage synchroniser for pin-level inputs
// ******************************************************************
module ssme_sync #(
   parameter WIDTH = 16
) (
   input wire clk,
   input wire rst,
   input wire ce,
   input wire [WIDTH-1:0] d,
   output reg [WIDTH-1:0] q
);

   reg [WIDTH-1:0] meta_q;

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta_q <= {WIDTH{1'b0}};
         q <= {WIDTH{1'b0}};
      end
      else if (ce)
      begin
         meta_q <= d;
         q <= meta_q;
      end
   end

endmodule
